//--- core/dihpm_top.v
`timescale 1ns/1ns
`include "dihpm_defs.vh"
// How it works
// RULE1: on the full variant the index pin feeds the decoder index input after reset.
// RULE2: on the full variant the home pin feeds the decoder home input after reset.
// RULE3: on the reduced variant neither pin has a function until software selects one.
// RULE4: the index alternate-select bit routes the index pin to serial data.
// RULE5: the home alternate-select bit routes the home pin to serial slave select.
// RULE6: clearing port c pull-up bit 2 turns off the index pin pull-up.
// RULE7: clearing port c pull-up bit 3 turns off the home pin pull-up.
// RULE8: in slave mode the data-out pin floats while slave select is not asserted.
// RULE9: a selected slave drives each bit half a serial clock before it is sampled.
// RULE10: slave select arbitrates in master mode and selects in slave mode.
// RULE11: in port mode each pin has its own direction bit.
// RULE12: with no other selection each pin stays on its decoder input.
module dihpm_top #(
  parameter FULL_VARIANT = 1
) (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // function selection
  input wire index_pin_alt_select,
  input wire home_pin_alt_select,
  input wire index_timer_select,
  input wire home_timer_select,
  input wire index_port_select,
  input wire home_port_select,
  input wire index_decoder_select,
  input wire home_decoder_select,
  input wire [3:2] port_c_pullup_enable,
  // port c bits
  input wire [3:2] port_c_dir_out,
  input wire [3:2] port_c_out,
  output reg [3:2] port_c_in_r,
  // timer channels
  input wire timer_b_chan2_oe,
  input wire timer_b_chan2_out,
  input wire timer_b_chan3_oe,
  input wire timer_b_chan3_out,
  output reg timer_b_chan2_in_r,
  output reg timer_b_chan3_in_r,
  // serial peripheral
  input wire serial_slave_mode,
  input wire serial_sclk_in,
  input wire serial_sample_rising,
  input wire serial_tx_bit,
  output reg serial_data_in_1_r,
  output reg serial_slave_selected_r,
  output reg serial_mode_fault_r,
  output reg serial_launch_r,
  // decoder inputs
  output reg decoder_index_in_r,
  output reg decoder_home_in_r,
  // index pin
  input wire index_pin_in,
  output wire index_pin_out,
  output wire index_pin_oe_n,
  output wire index_pin_pullup,
  // home pin
  input wire home_pin_in,
  output wire home_pin_out,
  output wire home_pin_oe_n,
  output wire home_pin_pullup,
  // status
  output reg [1:0] index_func_r,
  output reg [1:0] home_func_r,
  output reg index_func_valid_r,
  output reg home_func_valid_r
);
  // ==========================================================
  // function selection
  reg [1:0] index_fn_nxt;
  reg [1:0] home_fn_nxt;
  reg index_valid_nxt;
  reg home_valid_nxt;
  wire ss_low;
  wire slave_sel;
  wire so_out;
  wire so_oe;
  wire so_launch;

  // priority: alternate, port, timer, decoder
  always @* begin
    index_fn_nxt = `DIHPM_FN_DECODER; // RULE12
    index_valid_nxt = (FULL_VARIANT != 0) | index_decoder_select; // RULE1 RULE3
    if (index_pin_alt_select) begin
      index_fn_nxt = `DIHPM_FN_SERIAL; // RULE4
      index_valid_nxt = 1'b1;
    end else if (index_port_select) begin
      index_fn_nxt = `DIHPM_FN_PORT;
      index_valid_nxt = 1'b1;
    end else if (index_timer_select) begin
      index_fn_nxt = `DIHPM_FN_TIMER;
      index_valid_nxt = 1'b1;
    end
  end

  always @* begin
    home_fn_nxt = `DIHPM_FN_DECODER; // RULE12
    home_valid_nxt = (FULL_VARIANT != 0) | home_decoder_select; // RULE2 RULE3
    if (home_pin_alt_select) begin
      home_fn_nxt = `DIHPM_FN_SERIAL; // RULE5
      home_valid_nxt = 1'b1;
    end else if (home_port_select) begin
      home_fn_nxt = `DIHPM_FN_PORT;
      home_valid_nxt = 1'b1;
    end else if (home_timer_select) begin
      home_fn_nxt = `DIHPM_FN_TIMER;
      home_valid_nxt = 1'b1;
    end
  end

  // ==========================================================
  // slave select handling
  assign ss_low = home_func_valid_r & (home_func_r == `DIHPM_FN_SERIAL) & ~home_pin_in;
  assign slave_sel = serial_slave_mode & ss_low; // RULE10

  // ==========================================================
  // input routing registers
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      index_func_r <= `DIHPM_FN_DECODER;
      home_func_r <= `DIHPM_FN_DECODER;
      index_func_valid_r <= 1'b0;
      home_func_valid_r <= 1'b0;
      decoder_index_in_r <= 1'b0;
      decoder_home_in_r <= 1'b0;
      timer_b_chan2_in_r <= 1'b0;
      timer_b_chan3_in_r <= 1'b0;
      serial_data_in_1_r <= 1'b0;
      serial_slave_selected_r <= 1'b0;
      serial_mode_fault_r <= 1'b0;
      serial_launch_r <= 1'b0;
      port_c_in_r <= 2'h0;
    end else begin
      index_func_r <= index_fn_nxt;
      home_func_r <= home_fn_nxt;
      index_func_valid_r <= index_valid_nxt;
      home_func_valid_r <= home_valid_nxt;
      decoder_index_in_r <= index_func_valid_r & (index_func_r == `DIHPM_FN_DECODER)
        & index_pin_in; // RULE1
      decoder_home_in_r <= home_func_valid_r & (home_func_r == `DIHPM_FN_DECODER)
        & home_pin_in; // RULE2
      timer_b_chan2_in_r <= (index_func_r == `DIHPM_FN_TIMER) & index_pin_in;
      timer_b_chan3_in_r <= (home_func_r == `DIHPM_FN_TIMER) & home_pin_in;
      serial_data_in_1_r <= (index_func_r == `DIHPM_FN_SERIAL) & index_pin_in; // RULE4
      serial_slave_selected_r <= slave_sel; // RULE10
      serial_mode_fault_r <= ~serial_slave_mode & ss_low; // RULE10
      serial_launch_r <= so_launch;
      port_c_in_r[`DIHPM_INDEX_BIT] <= (index_func_r == `DIHPM_FN_PORT) & index_pin_in;
      port_c_in_r[`DIHPM_HOME_BIT] <= (home_func_r == `DIHPM_FN_PORT) & home_pin_in;
    end
  end

  // ==========================================================
  // slave data out on the index pin
  dihpm_slave_out u_so (
    .clk_sys(clk_sys),
    .rst(rst),
    .slave_mode(serial_slave_mode),
    .selected(slave_sel),
    .sclk_in(serial_sclk_in),
    .sample_rising(serial_sample_rising),
    .tx_bit(serial_tx_bit),
    .data_out_r(so_out),
    .data_oe_r(so_oe),
    .launch_r(so_launch)
  );

  // ==========================================================
  // pads
  dihpm_pad u_index (
    .clk_sys(clk_sys),
    .rst(rst),
    .func(index_func_r),
    .func_valid(index_func_valid_r),
    .pullup_en(port_c_pullup_enable[`DIHPM_INDEX_BIT]), // RULE6
    .port_dir_out(port_c_dir_out[`DIHPM_INDEX_BIT]), // RULE11
    .port_out(port_c_out[`DIHPM_INDEX_BIT]),
    .timer_oe(timer_b_chan2_oe),
    .timer_out(timer_b_chan2_out),
    .serial_oe(so_oe), // RULE8
    .serial_out(so_out), // RULE9
    .pad_out_r(index_pin_out),
    .pad_oe_n_r(index_pin_oe_n),
    .pad_pullup_r(index_pin_pullup)
  );

  // slave select is input only, so serial drive is off
  dihpm_pad u_home (
    .clk_sys(clk_sys),
    .rst(rst),
    .func(home_func_r),
    .func_valid(home_func_valid_r),
    .pullup_en(port_c_pullup_enable[`DIHPM_HOME_BIT]), // RULE7
    .port_dir_out(port_c_dir_out[`DIHPM_HOME_BIT]), // RULE11
    .port_out(port_c_out[`DIHPM_HOME_BIT]),
    .timer_oe(timer_b_chan3_oe),
    .timer_out(timer_b_chan3_out),
    .serial_oe(1'b0),
    .serial_out(1'b0),
    .pad_out_r(home_pin_out),
    .pad_oe_n_r(home_pin_oe_n),
    .pad_pullup_r(home_pin_pullup)
  );
endmodule

//--- pkg/dihpm_defs.vh
`ifndef DIHPM_DEFS_VH
`define DIHPM_DEFS_VH
// ==========================================================
// pin function codes
`define DIHPM_FN_DECODER 2'h0
`define DIHPM_FN_TIMER   2'h1
`define DIHPM_FN_SERIAL  2'h2
`define DIHPM_FN_PORT    2'h3
// ==========================================================
// port c bit positions of the two pins
`define DIHPM_INDEX_BIT 2
`define DIHPM_HOME_BIT  3
// ==========================================================
// reset values
`define DIHPM_PULLUP_RST 1'b1
`define DIHPM_PORT_RST   1'b0
`endif

//--- core/dihpm_pad.v
`timescale 1ns/1ns
`include "dihpm_defs.vh"
// ==========================================================
// one multiplexed pad: picks the owner of the output and registers the pull-up
module dihpm_pad (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // control
  input wire [1:0] func,
  input wire func_valid,
  input wire pullup_en,
  input wire port_dir_out,
  input wire port_out,
  input wire timer_oe,
  input wire timer_out,
  input wire serial_oe,
  input wire serial_out,
  // registered pad drive
  output reg pad_out_r,
  output reg pad_oe_n_r,
  output reg pad_pullup_r
);
  reg out_nxt;
  reg oe_nxt;

  // choose pad drive from the selected function
  always @* begin
    out_nxt = 1'b0;
    oe_nxt = 1'b0;
    if (func_valid) begin
      case (func)
        `DIHPM_FN_TIMER: begin
          out_nxt = timer_out;
          oe_nxt = timer_oe;
        end
        `DIHPM_FN_SERIAL: begin
          out_nxt = serial_out;
          oe_nxt = serial_oe;
        end
        `DIHPM_FN_PORT: begin
          out_nxt = port_out;
          oe_nxt = port_dir_out; // RULE11
        end
        default: begin
          out_nxt = 1'b0;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // pad drive registers; enable is low while driving
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pad_out_r <= 1'b0;
      pad_oe_n_r <= 1'b1;
      pad_pullup_r <= `DIHPM_PULLUP_RST;
    end else begin
      pad_out_r <= out_nxt;
      pad_oe_n_r <= ~oe_nxt;
      pad_pullup_r <= pullup_en;
    end
  end
endmodule

//--- core/dihpm_slave_out.v
`timescale 1ns/1ns
`include "dihpm_defs.vh"
// ==========================================================
// slave data-out launcher: shifts on the opposite edge to sampling
module dihpm_slave_out (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // serial controls
  input wire slave_mode,
  input wire selected,
  input wire sclk_in,
  input wire sample_rising,
  input wire tx_bit,
  // launched data
  output reg data_out_r,
  output reg data_oe_r,
  output reg launch_r
);
  reg sclk_d_r;
  wire launch_edge;

  // launch on the edge opposite the master's sampling edge
  assign launch_edge = sample_rising ? (sclk_d_r & ~sclk_in) : (~sclk_d_r & sclk_in);

  // sclk history and data launch
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclk_d_r <= 1'b0;
      data_out_r <= 1'b0;
      data_oe_r <= 1'b0;
      launch_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_in;
      launch_r <= slave_mode & selected & launch_edge;
      data_oe_r <= slave_mode & selected; // RULE8
      if (slave_mode & selected & (launch_edge | ~data_oe_r))
        data_out_r <= tx_bit; // RULE9
    end
  end
endmodule

//--- dv/dihpm_properties.sv
`timescale 1ns/1ns
`include "dihpm_defs.vh"
// ==========================================================
// checker on the top ports
module dihpm_properties (
  // clock, reset and watched ports
  input wire clk_sys, rst, index_pin_alt_select, home_pin_alt_select,
  input wire index_port_select, index_timer_select,
  input wire [3:2] port_c_pullup_enable, port_c_dir_out, port_c_out,
  input wire serial_slave_mode, serial_sclk_in, serial_sample_rising,
  input wire serial_slave_selected_r, serial_mode_fault_r, serial_launch_r,
  input wire decoder_index_in_r, index_pin_in, index_pin_out, index_pin_oe_n,
  input wire index_pin_pullup, home_pin_in, home_pin_pullup,
  input wire [1:0] index_func_r, home_func_r,
  input wire index_func_valid_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // index pin with no other selection
  sequence s_idle;
    !index_pin_alt_select && !index_port_select && !index_timer_select;
  endsequence
  // home pin in serial use and held low
  sequence s_home_low;
    home_func_r == `DIHPM_FN_SERIAL && !home_pin_in;
  endsequence
  property p_alt;
    index_pin_alt_select |=> index_func_r == `DIHPM_FN_SERIAL;
  endproperty
  a_alt: assert property (p_alt) else $error("index_pin_alt_select not serial");
  property p_home;
    home_pin_alt_select |=> home_func_r == `DIHPM_FN_SERIAL;
  endproperty
  a_home: assert property (p_home) else $error("home_pin_alt_select not serial");
  property p_dec;
    s_idle [*3] |-> index_func_r == `DIHPM_FN_DECODER && index_func_valid_r;
  endproperty
  a_dec: assert property (p_dec) else $error("index left decoder");
  property p_route;
    (!index_pin_alt_select && !index_port_select && !index_timer_select
      && $stable(index_pin_in)) [*4] |-> decoder_index_in_r == index_pin_in;
  endproperty
  a_route: assert property (p_route) else $error("decoder route wrong");
  property p_pull_i;
    (!port_c_pullup_enable[2]) [*3] |-> !index_pin_pullup;
  endproperty
  a_pull_i: assert property (p_pull_i) else $error("index pull-up on");
  property p_pull_h;
    (!port_c_pullup_enable[3]) [*3] |-> !home_pin_pullup;
  endproperty
  a_pull_h: assert property (p_pull_h) else $error("home pull-up on");
  property p_float;
    (index_func_r == `DIHPM_FN_SERIAL && serial_slave_mode
      && !serial_slave_selected_r) [*3] |-> index_pin_oe_n;
  endproperty
  a_float: assert property (p_float) else $error("data out driven");
  property p_sel;
    s_home_low ##0 serial_slave_mode |-> ##[1:2] serial_slave_selected_r;
  endproperty
  a_sel: assert property (p_sel) else $error("slave not selected");
  property p_fault;
    s_home_low ##0 !serial_slave_mode |-> ##[1:2] serial_mode_fault_r;
  endproperty
  a_fault: assert property (p_fault) else $error("no mode fault");
  property p_port;
    (index_port_select && !index_pin_alt_select && port_c_dir_out[2]
      && $stable(port_c_out[2])) [*3] |-> !index_pin_oe_n && index_pin_out == port_c_out[2];
  endproperty
  a_port: assert property (p_port) else $error("port drive wrong");
  property p_launch;
    serial_slave_selected_r && (serial_sample_rising ? $fell(serial_sclk_in)
      : $rose(serial_sclk_in)) |-> ##[1:3] serial_launch_r;
  endproperty
  a_launch: assert property (p_launch) else $error("no launch");
endmodule
bind dihpm_top dihpm_properties dihpm_properties_inst (.*);

//--- dv/dihpm_partner.sv
`timescale 1ns/1ns
// ==========================================================
// far side: pin levels and a serial master
module dihpm_partner (
  input wire clk_sys, frame, rise,
  input wire [1:0] pad_out, pad_oe_n, pad_pull, ext_en, ext_val,
  output wire [1:0] pin,
  output reg sclk = 1'b0,
  output reg miso_bit = 1'b0
);
  reg [1:0] last = 2'h0;
  reg [1:0] div = 2'h0;
  // design drive, outside drive, pull-up, else the inverse of the last level
  assign pin = ~pad_oe_n & pad_out
    | pad_oe_n & (ext_en & ext_val | ~ext_en & (pad_pull | ~last));
  // serial clock runs only inside a frame and rests low
  always @(posedge clk_sys) begin
    last <= pin;
    div <= frame ? div + 2'h1 : 2'h0;
    if (!frame) sclk <= 1'b0;
    else if (div == 2'h3) sclk <= ~sclk;
  end
  // master takes the slave bit on its chosen serial clock edge
  always @(sclk) begin
    if (sclk == rise) miso_bit <= pin[0];
  end
endmodule

//--- dv/dihpm_tb_top.sv
`timescale 1ns/1ns
// ==========================================================
// bench
module dihpm_tb_top;
  reg clk_sys, rst, sm, tx, frame, srise;
  reg [1:0] alt, psel, tsel, dsel, toe, tout, pu, dir, po, ext_en, ext_val;
  reg [31:0] r;
  integer bad_count, samples_checked, n, m;
  wire [1:0] ifn, hfn, vld, oen, pout, pull, pin, dec, tin, pcin;
  wire sdi, ssel, mflt, sclk, miso_bit;
  dihpm_top dihpm_top_inst (.clk_sys(clk_sys), .rst(rst),
    .index_pin_alt_select(alt[0]), .home_pin_alt_select(alt[1]),
    .index_timer_select(tsel[0]), .home_timer_select(tsel[1]),
    .index_port_select(psel[0]), .home_port_select(psel[1]),
    .index_decoder_select(dsel[0]), .home_decoder_select(dsel[1]),
    .port_c_pullup_enable(pu), .port_c_dir_out(dir), .port_c_out(po), .port_c_in_r(pcin),
    .timer_b_chan2_oe(toe[0]), .timer_b_chan2_out(tout[0]), .timer_b_chan3_oe(toe[1]),
    .timer_b_chan3_out(tout[1]), .timer_b_chan2_in_r(tin[0]), .timer_b_chan3_in_r(tin[1]),
    .serial_slave_mode(sm), .serial_sclk_in(sclk), .serial_sample_rising(srise),
    .serial_tx_bit(tx), .serial_data_in_1_r(sdi), .serial_slave_selected_r(ssel),
    .serial_mode_fault_r(mflt), .serial_launch_r(), .decoder_index_in_r(dec[0]),
    .decoder_home_in_r(dec[1]), .index_pin_in(pin[0]), .index_pin_out(pout[0]),
    .index_pin_oe_n(oen[0]), .index_pin_pullup(pull[0]), .home_pin_in(pin[1]),
    .home_pin_out(pout[1]), .home_pin_oe_n(oen[1]), .home_pin_pullup(pull[1]),
    .index_func_r(ifn), .home_func_r(hfn), .index_func_valid_r(vld[0]),
    .home_func_valid_r(vld[1]));
  dihpm_partner dihpm_partner_inst (.clk_sys(clk_sys), .frame(frame), .rise(srise),
    .pad_out(pout),
    .pad_oe_n(oen), .pad_pull(pull), .ext_en(ext_en), .ext_val(ext_val), .pin(pin),
    .sclk(sclk), .miso_bit(miso_bit));
  // compare and count
  task check(input [7:0] seen, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  // verdict and end of run
  task wrap_up;
    begin
      $display("checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // wait edges, then step off the edge
  task tick(input integer c);
    begin
      repeat (c) @(posedge clk_sys);
      #1;
    end
  endtask
  // reference of one pin: alt, then port, then timer, then decoder
  task chk_pin(input integer k);
    integer f, drv, p;
    begin
      f = alt[k] ? 2 : psel[k] ? 3 : tsel[k] ? 1 : 0;
      drv = f == 3 ? dir[k] : f == 1 ? toe[k] : 0;
      p = drv ? (f == 3 ? po[k] : tout[k]) : ext_val[k];
      check(k ? hfn : ifn, f[7:0]);
      check(vld[k], 8'h01);
      check(oen[k], !drv);
      check(dec[k], f == 0 && p);
      check(pcin[k], f == 3 && p);
      check(tin[k], f == 1 && p);
      if (!drv) check(pull[k], pu[k]);
      if (k == 0) check(sdi, f == 2 && p);
      if (k == 1) check(mflt, f == 2 && !p);
    end
  endtask
  // clock
  initial begin
    clk_sys = 0;
    forever #4 clk_sys = ~clk_sys;
  end
  // watchdog
  initial begin
    #20000;
    bad_count = bad_count + 1;
    wrap_up;
  end
  // main sequence
  initial begin
    rst = 1;
    {alt, psel, tsel, dsel, toe, tout, pu, dir, po, ext_en, ext_val} = 22'h0;
    {sm, tx, frame, srise} = 4'h0;
    bad_count = 0;
    samples_checked = 0;
    r = $urandom(73418);
    repeat (5) @(posedge clk_sys);
    #1;
    check({oen, pull, vld}, 8'h3c);
    rst = 0;
    ext_en = 2'h3;
    pu = 2'h3;
    tick(4);
    check({ifn, hfn, vld}, 8'h03);
    // software sets each pin before use
    for (n = 0; n < 60; n = n + 1) begin
      r = $urandom;
      {alt, psel, tsel, dsel, toe, tout, pu, dir, po, ext_val} = r[19:0];
      tick(4);
      chk_pin(0);
      chk_pin(1);
    end
    // slave selected, two frames, then released
    alt = 2'h3;
    ext_en = 2'h2;
    ext_val = 2'h0;
    sm = 1;
    tx = r[20];
    tick(4);
    check({ssel, oen[0]}, 8'h02);
    // one frame per master sampling edge, a fresh bit after each sample
    for (m = 0; m < 2; m = m + 1) begin
      srise = (m == 0);
      frame = 1;
      for (n = 0; n < 5; n = n + 1) begin
        tick(8);
        check(miso_bit, tx);
        r = $urandom;
        tx = r[0];
      end
      frame = 0;
      tick(4);
    end
    ext_val = 2'h2;
    tick(4);
    check({ssel, oen[0]}, 8'h01);
    sm = 0;
    ext_val = 2'h0;
    tick(4);
    check(mflt, 8'h01);
    wrap_up;
  end
endmodule
